/* shared/srpg_pkg.sv */
// shared constants, types and fixed-point helpers for the ramp and phasor generator
// assumes every file that uses it imports the whole package
package srpg_pkg;

  // =========================================================================
  // number formats
  localparam int          WORD_W     = 32;
  localparam int          FRAC_BITS  = 16;
  localparam int          MSB_POS    = 31;
  localparam logic [31:0] FIX_ONE    = 32'h0001_0000;
  localparam logic [31:0] FRAC_MASK  = 32'h0000_ffff;
  localparam logic [31:0] FIX_MAX    = 32'h7fff_ffff;
  localparam logic [31:0] LOG_MIN    = 32'h8000_0000;
  localparam logic [47:0] TIME_ONE   = 48'h0000_0100_0000;

  // =========================================================================
  // parameter list layout: x1, first_segment_time, x2, dur2, x3 ...
  localparam int             PARAM_MAX  = 8;
  localparam int             IDX_W      = 4;
  localparam logic [IDX_W-1:0] IDX_ZERO   = 4'h0;
  localparam logic [IDX_W-1:0] IDX_ONE    = 4'h1;
  localparam logic [IDX_W-1:0] IDX_TWO    = 4'h2;
  localparam logic [IDX_W-1:0] IDX_THREE  = 4'h3;
  localparam logic [IDX_W-1:0] IDX_FOUR   = 4'h4;
  localparam logic [IDX_W-1:0] IDX_LIMIT  = 4'h8;

  // =========================================================================
  // divider and buffer
  localparam int          DIV_W      = 48;
  localparam logic [5:0]  DIV_STEPS  = 6'h30;
  localparam int          FIFO_DEPTH = 4;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ENV_STEP, ST_ENV_SEG, ST_ENV_OUT, ST_PH_STEP, ST_PH_WRAP, ST_DIV, ST_PUSH
  } srpg_state_t;

  typedef enum logic [1:0] {JOB_ENV_INC, JOB_ENV_Q, JOB_PH} srpg_job_t;

  // =========================================================================
  // signed Q16.16 product
  function automatic logic [31:0] srpg_mul(input logic [31:0] a, input logic [31:0] b);
    logic signed [63:0] p;
    p = $signed(a) * $signed(b);
    return p[47:16];
  endfunction

  // piecewise-linear log2 of a positive Q16.16 value, result signed Q16.16
  function automatic logic [31:0] srpg_log2(input logic [31:0] x);
    logic [31:0] sh;
    logic [15:0] ip;
    int          m;
    m = 0;
    for (int i = 0; i <= MSB_POS; i++) begin
      if (x[i]) begin
        m = i;
      end
    end
    sh = x << (MSB_POS - m);
    ip = 16'(m - FRAC_BITS);
    return (x == '0) ? LOG_MIN : {ip, sh[30:15]};
  endfunction

  // piecewise-linear exp2 of a signed Q16.16 value, result Q16.16
  function automatic logic [31:0] srpg_exp2(input logic [31:0] y);
    logic signed [15:0] k;
    logic [63:0]        mant;
    k = $signed(y[31:16]);
    mant = {32'h0, 16'h0001, y[15:0]};
    if (k > 16'sd14) begin
      return FIX_MAX;
    end else if (k < -16'sd17) begin
      return '0;
    end else if (k >= 0) begin
      return 32'(mant << k);
    end
    return 32'(mant >> (-k));
  endfunction

endpackage

/* rtl/srpg_fifo.sv */
// small shift-register FIFO; the head word sits in a register and drives the outputs
// assumes one clock and an active-high asynchronous reset
`timescale 1ns/1ns
`default_nettype none
module srpg_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  // =========================================================================
  // storage
  logic [WIDTH-1:0]       mem_r [DEPTH];
  logic [$clog2(DEPTH):0] count_r;
  logic [$clog2(DEPTH):0] count_nxt;
  logic                   push;
  logic                   pop;

  assign push = inValid && inReady;
  assign pop  = outValid && outReady;
  assign count_nxt = count_r + {{$clog2(DEPTH){1'b0}}, push} - {{$clog2(DEPTH){1'b0}}, pop};
  assign outData = mem_r[0];

  // shifting costs a mux per entry but keeps the head word in a flop
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (pop) begin
          if (push && (i == int'(count_r) - 1)) begin
            mem_r[i] <= inData;
          end else if (i < DEPTH - 1) begin
            mem_r[i] <= mem_r[i+1];
          end
        end else if (push && (i == int'(count_r))) begin
          mem_r[i] <= inData;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      count_r  <= '0;
      outValid <= 1'b0;
      inReady  <= 1'b1;
    end else begin
      count_r  <= count_nxt;
      outValid <= (count_nxt != '0);
      inReady  <= (int'(count_nxt) != DEPTH);
    end
  end
endmodule
`default_nettype wire

/* rtl/srpg_gen.sv */
// breakpoint envelope (linear or exponential) and wrapping phasor, advanced by tick strobes
// assumes a host that loads the parameter list after start and drains the sample stream
`timescale 1ns/1ns
`default_nettype none
module srpg_gen
  import srpg_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        startReq,
  input  wire logic        paramValid,
  input  wire logic [31:0] paramData,
  input  wire logic        expMode,
  input  wire logic        envAudioRate,
  input  wire logic        phaseAudioRate,
  input  wire logic [31:0] controlTickRate,
  input  wire logic [31:0] sampleTickRate,
  input  wire logic [31:0] cycleFreq,
  input  wire logic        ctrlTick,
  input  wire logic        audioTick,
  output logic             tickReady,
  output logic             sampleValid,
  input  wire logic        sampleReady,
  output logic [31:0]      envSample,
  output logic [31:0]      phaseSample,
  output logic             envDone,
  output logic             paramError
);
  // =========================================================================
  // state and storage
  srpg_state_t      state_r;
  srpg_state_t      state_nxt;
  srpg_job_t        divJob_r;
  logic [DIV_W-1:0] divQuot_r;
  logic [32:0]      divRem_r;
  logic [31:0]      divDen_r;
  logic [5:0]       divCnt_r;
  logic             divNeg_r;
  logic [31:0]      params_r [PARAM_MAX];
  logic [IDX_W-1:0] paramCnt_r;
  logic [IDX_W-1:0] segBase_r;
  logic             negDurSeen_r;
  logic             zeroSeen_r;
  logic             posSeen_r;
  logic             negSeen_r;
  logic             overflow_r;
  logic             envFirst_r;
  logic             phFirst_r;
  logic             envGo_r;
  logic             phGo_r;
  logic [31:0]      envTime_r;
  logic [31:0]      segLen_r;
  logic [31:0]      leftVal_r;
  logic [31:0]      rightVal_r;
  logic [31:0]      ratio_r;
  logic [31:0]      envValue_r;
  logic [31:0]      phase_r;
  logic             fifoInReady;
  logic [63:0]      fifoOut;

  logic        startTake;
  logic        tickTake;
  logic        divDone;
  logic [31:0] divResult;
  logic        moreSeg;
  logic        timeOver;
  logic        envInit;
  logic        errSet;
  logic [31:0] envRate;
  logic [31:0] phRate;

  function automatic logic [31:0] rdParam(input logic [IDX_W-1:0] idx);
    return (idx < IDX_LIMIT) ? params_r[idx[2:0]] : '0;
  endfunction

  function automatic logic [31:0] absVal(input logic [31:0] v);
    return v[31] ? (~v + 32'h0000_0001) : v;
  endfunction

  assign startTake = startReq && tickReady;
  assign tickTake  = (ctrlTick || audioTick) && tickReady && !startReq;
  assign divDone   = (state_r == ST_DIV) && (divCnt_r == '0);
  assign divResult = divNeg_r ? (~divQuot_r[31:0] + 32'h0000_0001) : divQuot_r[31:0];
  assign moreSeg   = (segBase_r + IDX_THREE) < paramCnt_r;
  assign timeOver  = $signed(envTime_r) > $signed(segLen_r);
  assign envInit   = (state_r == ST_ENV_STEP) && envGo_r && envFirst_r;
  assign envRate   = envAudioRate ? sampleTickRate : controlTickRate;
  assign phRate    = phaseAudioRate ? sampleTickRate : controlTickRate;

  // =========================================================================
  // sequencing: one accepted tick walks envelope, then phasor, then the push
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (tickTake) begin
          state_nxt = ST_ENV_STEP;
        end
      end
      ST_ENV_STEP: begin
        if (!envGo_r || (!envFirst_r && envDone)) begin
          state_nxt = ST_PH_STEP;
        end else if (envFirst_r) begin
          state_nxt = ST_ENV_SEG;
        end else begin
          state_nxt = ST_DIV;
        end
      end
      ST_ENV_SEG: begin
        if (timeOver) begin
          state_nxt = moreSeg ? ST_ENV_SEG : ST_PH_STEP;
        end else begin
          state_nxt = ST_DIV;
        end
      end
      ST_DIV: begin
        if (divDone) begin
          unique case (divJob_r)
            JOB_ENV_INC: state_nxt = ST_ENV_SEG;
            JOB_ENV_Q:   state_nxt = ST_ENV_OUT;
            default:     state_nxt = ST_PH_WRAP;
          endcase
        end
      end
      ST_ENV_OUT: state_nxt = ST_PH_STEP;
      ST_PH_STEP: begin
        state_nxt = (!phGo_r || phFirst_r) ? ST_PUSH : ST_DIV;
      end
      ST_PH_WRAP: state_nxt = ST_PUSH;
      ST_PUSH: begin
        if (fifoInReady) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_r   <= ST_IDLE;
      tickReady <= 1'b1;
      envGo_r   <= 1'b0;
      phGo_r    <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      tickReady <= (state_nxt == ST_IDLE);
      if (tickTake) begin
        envGo_r <= envAudioRate ? audioTick : ctrlTick;
        phGo_r  <= phaseAudioRate ? audioTick : ctrlTick;
      end
    end
  end

  // =========================================================================
  // shared restoring divider, 48 quotient bits, sign applied afterwards
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      divQuot_r <= '0;
      divRem_r  <= '0;
      divDen_r  <= '0;
      divCnt_r  <= '0;
      divNeg_r  <= 1'b0;
      divJob_r  <= JOB_ENV_INC;
    end else if (state_r == ST_DIV) begin
      if (divCnt_r != '0) begin
        divCnt_r <= divCnt_r - 6'h01;
        if ({divRem_r[31:0], divQuot_r[DIV_W-1]} >= {1'b0, divDen_r}) begin
          divRem_r  <= {divRem_r[31:0], divQuot_r[DIV_W-1]} - {1'b0, divDen_r};
          divQuot_r <= {divQuot_r[DIV_W-2:0], 1'b1};
        end else begin
          divRem_r  <= {divRem_r[31:0], divQuot_r[DIV_W-1]};
          divQuot_r <= {divQuot_r[DIV_W-2:0], 1'b0};
        end
      end
    end else if (state_nxt == ST_DIV) begin
      divRem_r <= '0;
      divCnt_r <= DIV_STEPS;
      if (state_r == ST_ENV_STEP) begin
        divQuot_r <= TIME_ONE;
        divDen_r  <= envRate;
        divNeg_r  <= 1'b0;
        divJob_r  <= JOB_ENV_INC;
      end else if (state_r == ST_ENV_SEG) begin
        divQuot_r <= {absVal(envTime_r), 16'h0000};
        divDen_r  <= absVal(segLen_r);
        divNeg_r  <= 1'b0;
        divJob_r  <= JOB_ENV_Q;
      end else begin
        divQuot_r <= {16'h0000, absVal(cycleFreq)};
        divDen_r  <= phRate;
        divNeg_r  <= cycleFreq[31];
        divJob_r  <= JOB_PH;
      end
    end
  end

  // =========================================================================
  // parameter list loading and validity bookkeeping
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < PARAM_MAX; i++) begin
        params_r[i] <= '0;
      end
      paramCnt_r   <= IDX_ZERO;
      negDurSeen_r <= 1'b0;
      zeroSeen_r   <= 1'b0;
      posSeen_r    <= 1'b0;
      negSeen_r    <= 1'b0;
      overflow_r   <= 1'b0;
    end else if (startTake) begin
      paramCnt_r   <= IDX_ZERO;
      negDurSeen_r <= 1'b0;
      zeroSeen_r   <= 1'b0;
      posSeen_r    <= 1'b0;
      negSeen_r    <= 1'b0;
      overflow_r   <= 1'b0;
    end else if (paramValid && tickReady) begin
      if (paramCnt_r < IDX_LIMIT) begin
        params_r[paramCnt_r[2:0]] <= paramData;
        paramCnt_r <= paramCnt_r + IDX_ONE;
        if (paramCnt_r[0]) begin
          negDurSeen_r <= negDurSeen_r || paramData[31];
        end else begin
          zeroSeen_r <= zeroSeen_r || (paramData == '0);
          posSeen_r  <= posSeen_r || (!paramData[31] && paramData != '0);
          negSeen_r  <= negSeen_r || paramData[31];
        end
      end else begin
        overflow_r <= 1'b1;
      end
    end
  end

  // too short, too long, or even-length lists are all malformed
  assign errSet = envInit && (!paramCnt_r[0] || (paramCnt_r < IDX_THREE) || negDurSeen_r
                  || overflow_r || (expMode && (zeroSeen_r || (posSeen_r && negSeen_r))));

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      paramError <= 1'b0;
    end else if (errSet) begin
      paramError <= 1'b1;
    end else if (startTake) begin
      paramError <= 1'b0;
    end
  end

  // =========================================================================
  // envelope
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      envFirst_r <= 1'b1;
      envDone    <= 1'b0;
      envTime_r  <= '0;
      segLen_r   <= '0;
      leftVal_r  <= '0;
      rightVal_r <= '0;
      segBase_r  <= IDX_ZERO;
      ratio_r    <= '0;
      envValue_r <= '0;
    end else if (startTake) begin
      envFirst_r <= 1'b1;
      envDone    <= 1'b0;
      envValue_r <= '0;
    end else if (envInit) begin
      envFirst_r <= 1'b0;
      envDone    <= 1'b0;
      envTime_r  <= '0;
      leftVal_r  <= rdParam(IDX_ZERO);
      segLen_r   <= rdParam(IDX_ONE);
      rightVal_r <= rdParam(IDX_TWO);
      segBase_r  <= IDX_ZERO;
    end else if (divDone && divJob_r == JOB_ENV_INC) begin
      envTime_r <= envTime_r + divResult;
    end else if (state_r == ST_ENV_SEG && timeOver) begin
      if (moreSeg) begin
        envTime_r  <= envTime_r - segLen_r;
        segBase_r  <= segBase_r + IDX_TWO;
        leftVal_r  <= rightVal_r;
        segLen_r   <= rdParam(segBase_r + IDX_THREE);
        rightVal_r <= rdParam(segBase_r + IDX_FOUR);
      end else begin
        envDone    <= 1'b1;
        envValue_r <= '0;
      end
    end else if (divDone && divJob_r == JOB_ENV_Q) begin
      // a zero-length segment counts as already complete
      ratio_r <= (divDen_r == '0) ? FIX_ONE : divResult;
    end else if (state_r == ST_ENV_OUT) begin
      // exp curve uses straight-line log and exp segments, up to about 0.5 dB of error
      if (expMode) begin
        envValue_r <= leftVal_r[31] ? (~expMag() + 32'h0000_0001) : expMag();
      end else begin
        envValue_r <= leftVal_r + srpg_mul(rightVal_r - leftVal_r, ratio_r);
      end
    end
  end

  function automatic logic [31:0] expMag();
    logic [31:0] lg;
    lg = srpg_log2(absVal(rightVal_r)) - srpg_log2(absVal(leftVal_r));
    return srpg_mul(absVal(leftVal_r), srpg_exp2(srpg_mul(lg, ratio_r)));
  endfunction

  // =========================================================================
  // phasor
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      phFirst_r <= 1'b1;
      phase_r   <= '0;
    end else if (startTake) begin
      phFirst_r <= 1'b1;
    end else if (state_r == ST_PH_STEP && phGo_r && phFirst_r) begin
      phFirst_r <= 1'b0;
      phase_r   <= '0;
    end else if (divDone && divJob_r == JOB_PH) begin
      phase_r <= phase_r + divResult;
    end else if (state_r == ST_PH_WRAP) begin
      if ($signed(phase_r) > $signed(FIX_ONE) || phase_r[31]) begin
        phase_r <= phase_r & FRAC_MASK;
      end
    end
  end

  // =========================================================================
  // output buffer; a full buffer holds the walk in push and so drops tick ready
  srpg_fifo #(
    .WIDTH (64),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .inValid  (state_r == ST_PUSH),
    .inReady  (fifoInReady),
    .inData   ({envValue_r, phase_r}),
    .outValid (sampleValid),
    .outReady (sampleReady),
    .outData  (fifoOut)
  );

  assign envSample   = fifoOut[63:32];
  assign phaseSample = fifoOut[31:0];

  // =========================================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_init;
    envInit |=> (envTime_r == '0 && segBase_r == IDX_ZERO && !envFirst_r);
  endproperty
  a_init: assert property (p_init) else $error("envelope not set up on first tick");

  property p_env_rate;
    (state_r == ST_ENV_STEP && state_nxt == ST_DIV) |=>
      (divDen_r == ($past(envAudioRate) ? $past(sampleTickRate) : $past(controlTickRate)));
  endproperty
  a_env_rate: assert property (p_env_rate) else $error("envelope step uses wrong rate");

  property p_seg_step;
    (state_r == ST_ENV_SEG && timeOver && moreSeg) |=>
      (segBase_r == $past(segBase_r) + IDX_TWO && leftVal_r == $past(rightVal_r));
  endproperty
  a_seg_step: assert property (p_seg_step) else $error("segment did not advance");

  property p_done;
    (state_r == ST_ENV_SEG && timeOver && !moreSeg) |=> (envDone && envValue_r == '0);
  endproperty
  a_done: assert property (p_done) else $error("envelope not done at end");

  property p_done_zero;
    (state_r == ST_PUSH && envDone) |-> (envValue_r == '0);
  endproperty
  a_done_zero: assert property (p_done_zero) else $error("done envelope pushed nonzero");

  property p_lin_start;
    (state_r == ST_ENV_OUT && !expMode && ratio_r == '0) |=> (envValue_r == $past(leftVal_r));
  endproperty
  a_lin_start: assert property (p_lin_start) else $error("linear start is not left");

  property p_err_set;
    errSet |=> paramError;
  endproperty
  a_err_set: assert property (p_err_set) else $error("bad parameters not flagged");

  property p_err_sticky;
    (paramError && !startTake) |=> paramError;
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("error flag dropped");

  property p_phase_range;
    (state_r == ST_PH_WRAP) |=> (!phase_r[31] && $signed(phase_r) <= $signed(FIX_ONE));
  endproperty
  a_phase_range: assert property (p_phase_range) else $error("phase left unit range");

  property p_tick_bound;
    tickTake |-> ##[1:200] (state_r == ST_PUSH);
  endproperty
  a_tick_bound: assert property (p_tick_bound) else $error("tick walk did not finish");
endmodule
`default_nettype wire

/* dv/srpg_host_model.sv */
// host-side sink model: drains the sample stream and records every word it takes
// assumes the bench drives stall and reads got through the hierarchy
`timescale 1ns/1ns
`default_nettype none
module srpg_host_model (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        stall,
  input  wire logic        sampleValid,
  input  wire logic [31:0] envSample,
  input  wire logic [31:0] phaseSample,
  output logic             sampleReady
);
  // =========================================================================
  // drain
  logic [63:0] got[$];
  // nonblocking, so this model and the generator see the same ready at each edge
  always @(posedge clk_sys) begin
    if (sampleValid === 1'b1 && sampleReady) begin
      got.push_back({envSample, phaseSample});
    end
    sampleReady <= !stall && !reset;
  end
endmodule
`default_nettype wire

/* dv/srpg_gen_tb_top.sv */
// bench for the ramp and phasor generator: linear, segments, stall, exponential, errors
// assumes srpg_gen, srpg_fifo and srpg_host_model are compiled before it
`timescale 1ns/1ns
`default_nettype none
module srpg_gen_tb_top;
  // =========================================================================
  // signals
  logic        clk_sys, reset, startReq, paramValid, expMode, envAudioRate, phaseAudioRate;
  logic        ctrlTick, audioTick, tickReady, sampleValid, sampleReady, envDone;
  logic        paramError, stall;
  logic [31:0] paramData, envSample, phaseSample, controlTickRate, sampleTickRate, cycleFreq;
  int          err_total, n_checks;

  srpg_gen DUT (.clk_sys, .reset, .startReq, .paramValid, .paramData, .expMode, .envAudioRate,
    .phaseAudioRate, .controlTickRate, .sampleTickRate, .cycleFreq, .ctrlTick, .audioTick,
    .tickReady, .sampleValid, .sampleReady, .envSample, .phaseSample, .envDone, .paramError);
  srpg_host_model host (.clk_sys, .reset, .stall, .sampleValid, .envSample, .phaseSample,
    .sampleReady);

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // =========================================================================
  // helpers
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // tolerance only for the exponential curve, whose log and exp are approximated
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input int tol = 0);
    logic [31:0] d;
    d = (seen > exp) ? seen - exp : exp - seen;
    n_checks++;
    if (seen !== exp && ($isunknown(seen) || d > tol)) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #1;
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (tickReady !== 1'b1 && n < 500) begin
      cyc(1);
      n++;
    end
    // a walk that never comes back counts against the run
    chk(tickReady, 1'b1);
  endtask

  task automatic run_start(input logic [31:0] w[5], input int nw, input logic ex,
                           input logic ea, input logic pa);
    wait_ready();
    expMode = ex;
    envAudioRate = ea;
    phaseAudioRate = pa;
    startReq = 1'b1;
    cyc(1);
    startReq = 1'b0;
    for (int i = 0; i < nw; i++) begin
      paramValid = 1'b1;
      paramData = w[i];
      cyc(1);
    end
    paramValid = 1'b0;
    host.got.delete();
  endtask

  task automatic tick(input logic c, input logic a);
    wait_ready();
    ctrlTick = c;
    audioTick = a;
    cyc(1);
    ctrlTick = 1'b0;
    audioTick = 1'b0;
    cyc(2);
  endtask

  task automatic expect_word(input logic [31:0] e, input logic [31:0] p, input int tol = 0);
    logic [63:0] w;
    int n;
    n = 0;
    while (host.got.size() == 0 && n < 500) begin
      cyc(1);
      n++;
    end
    w = 'x;
    if (host.got.size() > 0) w = host.got.pop_front();
    chk(w[63:32], e, tol);
    chk(w[31:0], p);
  endtask

  // =========================================================================
  // scenarios
  task automatic sc_linear();
    logic [31:0] ev[6] = '{32'h1_0000, 32'h2_0000, 32'h3_0000, 32'h4_0000, 32'h5_0000, '0};
    logic [31:0] pv[6] = '{'0, 32'h6000, 32'hc000, 32'h2000, 32'h8000, 32'he000};
    run_start('{32'h1_0000, 32'h0100_0000, 32'h5_0000, '0, '0}, 3, 1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 6; i++) begin
      tick(1'b1, 1'b1);
      expect_word(ev[i], pv[i]);
    end
    chk(envDone, 1'b1);
  endtask

  task automatic sc_segments();
    logic [31:0] ev[6] = '{'0, 32'h1_0000, 32'h2_0000, 32'h1_0000, '0, '0};
    logic [31:0] pv[6] = '{'0, 32'hc000, 32'h8000, 32'h4000, 32'h1_0000, 32'hc000};
    run_start('{'0, 32'h0080_0000, 32'h2_0000, 32'h0080_0000, '0}, 5, 1'b0, 1'b0, 1'b0);
    stall = 1'b1;
    repeat (5) tick(1'b1, 1'b0);
    cyc(300);
    chk(tickReady, 1'b0);
    chk(sampleValid, 1'b1);
    chk(32'(host.got.size()), '0);
    stall = 1'b0;
    tick(1'b1, 1'b0);
    for (int i = 0; i < 6; i++) begin
      expect_word(ev[i], pv[i]);
    end
  endtask

  task automatic sc_expo();
    logic [31:0] ev[5] = '{32'h1_0000, 32'h1_6a0a, 32'h2_0000, 32'h2_d414, 32'h4_0000};
    int          tl[5] = '{32'h100, 32'h3000, 32'h100, 32'h3000, 32'h100};
    run_start('{32'h1_0000, 32'h0080_0000, 32'h4_0000, '0, '0}, 3, 1'b1, 1'b1, 1'b0);
    for (int i = 0; i < 5; i++) begin
      tick(1'b0, 1'b1);
      // no control tick here, so the phasor holds its last phase from the segment run
      expect_word(ev[i], 32'h0000_c000, tl[i]);
    end
    chk(paramError, 1'b0);
  endtask

  task automatic sc_errors();
    logic [31:0] l[5][5] = '{
      '{32'h1_0000, 32'h0100_0000, '0, '0, '0},
      '{32'h1_0000, 32'hff00_0000, 32'h2_0000, '0, '0},
      '{32'h1_0000, 32'h0100_0000, '0, '0, '0},
      '{32'h1_0000, 32'h0100_0000, 32'hfffe_0000, '0, '0},
      '{32'hffff_0000, 32'h0100_0000, 32'hfffc_0000, '0, '0}};
    int   nw[5] = '{2, 3, 3, 3, 3};
    logic ex[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    logic er[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    for (int k = 0; k < 5; k++) begin
      run_start(l[k], nw[k], ex[k], 1'b0, 1'b0);
      chk(paramError, 1'b0);
      tick(1'b1, 1'b0);
      tick(1'b1, 1'b0);
      chk(paramError, er[k]);
    end
  endtask

  // =========================================================================
  // main sequence and watchdog
  initial begin
    {reset, startReq, paramValid, expMode, envAudioRate} = 5'h10;
    {phaseAudioRate, ctrlTick, audioTick, stall} = 4'h0;
    paramData = '0;
    controlTickRate = 32'h4;
    sampleTickRate = 32'h8;
    cycleFreq = 32'h3_0000;
    err_total = 0;
    n_checks = 0;
    repeat (16) @(posedge clk_sys);
    #1 reset = 1'b0;
    chk(paramError, 1'b0);
    sc_linear();
    sc_segments();
    sc_expo();
    sc_errors();
    report_and_stop();
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule
`default_nettype wire
